// ---- hw/sram_sleep_mode_control.sv ----
// Module: sleep-mode sequencer for a pipelined synchronous burst SRAM
// Function
// - Two clock cycles after the sleep request goes high the memory enters sleep.
// - In sleep all internal state except the output enable, and the stored contents, are kept unchanged.
// - After the request falls, writes resume only once the recovery time has passed; reads pass during recovery.
// - Sleep lasts while the request stays high and ends one edge after it falls; the memory counts as deselected.
// - In sleep the command and read-data inputs are ignored; data outputs float from one edge after sleep begins.
// - The request is asynchronous active high; operations in flight when it rises may be lost.
`timescale 1ns/100ps
module sram_sleep_mode_control
   import ssmc_pkg::*;
#(
   parameter int DATA_W = 36
) (
   // Clock, reset, enable
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // Sleep request from controller
   input  wire logic              sleepRequest,
   // Commands from the controller
   input  wire logic              cmdSelect,
   input  wire logic              cmdRead,
   input  wire logic              cmdWrite,
   // Read data from the array pipeline
   input  wire logic [DATA_W-1:0] rdData,
   input  wire logic              rdValid,
   // Gated commands towards the array
   output logic                   memRead,
   output logic                   memWrite,
   // Data pins
   output logic [DATA_W-1:0]      dqOut,
   output logic                   dqOe,
   // Status
   output logic                   asleep,
   output logic                   recovering
);
   ssmc_state_t       state;
   ssmc_state_t       next_state;
   logic [CNT_W-1:0]  cnt;
   logic [CNT_W-1:0]  next_cnt;

   ssmc_if #(.DATA_W(DATA_W)) bus ();

   // Phase sequencer next state
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         SSMC_RUN: begin
            if (sleepRequest) begin
               next_state = SSMC_ENTER;
               next_cnt   = ssmc_cnt(SLEEP_ENTRY_CYC - 1);
            end
         end
         SSMC_ENTER: begin
            if (!sleepRequest) begin
               next_state = SSMC_RUN;
            end else if (cnt <= ssmc_cnt(1)) begin
               next_state = SSMC_SLEEP;
            end else begin
               next_cnt = cnt - ssmc_cnt(1);
            end
         end
         SSMC_SLEEP: begin
            if (!sleepRequest) begin
               next_state = SSMC_RECOVER;
               next_cnt   = ssmc_cnt(RECOVERY_CYC);
            end
         end
         SSMC_RECOVER: begin
            if (sleepRequest) begin
               next_state = SSMC_ENTER;
               next_cnt   = ssmc_cnt(SLEEP_ENTRY_CYC - 1);
            end else if (cnt <= ssmc_cnt(1)) begin
               next_state = SSMC_RUN;
            end else begin
               next_cnt = cnt - ssmc_cnt(1);
            end
         end
         default: begin
            next_state = SSMC_RUN;
            next_cnt   = CNT_RESET;
         end
      endcase
   end

   // Phase registers
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= SSMC_RUN;
         cnt   <= CNT_RESET;
      end else if (ce) begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // Status and bundle hookup
   assign asleep         = (state == SSMC_SLEEP);
   assign recovering     = (state == SSMC_RECOVER);
   assign bus.asleep     = asleep;
   assign bus.recovering = recovering;
   assign bus.cmdSelect  = cmdSelect;
   assign bus.cmdRead    = cmdRead;
   assign bus.cmdWrite   = cmdWrite;
   assign bus.rdData     = rdData;
   assign bus.rdValid    = rdValid;
   assign memRead        = bus.memRead;
   assign memWrite       = bus.memWrite;
   assign dqOut          = bus.outData;
   assign dqOe           = bus.outEn;

   ssmc_gate #(.DATA_W(DATA_W)) u_gate (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .bus (bus.gate)
   );

   // Entry takes the two sampled edges
   sequence s_enter;
      !sleepRequest ##1 sleepRequest [*3];
   endsequence
   property p_entry;
      @(posedge clk) disable iff (rst || !ce)
      (state == SSMC_RUN) ##0 s_enter |-> asleep;
   endproperty
   a_entry: assert property (p_entry) else $error("sleep not entered two cycles after request");

   property p_not_early;
      @(posedge clk) disable iff (rst || !ce)
      (state == SSMC_RUN && sleepRequest) |=> !asleep;
   endproperty
   a_not_early: assert property (p_not_early) else $error("sleep entered too early");

   property p_hold;
      @(posedge clk) disable iff (rst || !ce)
      (asleep && sleepRequest) |=> asleep;
   endproperty
   a_hold: assert property (p_hold) else $error("sleep left while request high");

   property p_exit;
      @(posedge clk) disable iff (rst || !ce)
      (asleep && !sleepRequest) |=> !asleep;
   endproperty
   a_exit: assert property (p_exit) else $error("sleep kept after request low");

   property p_quiet;
      @(posedge clk) disable iff (rst)
      asleep |-> !memRead && !memWrite;
   endproperty
   a_quiet: assert property (p_quiet) else $error("array touched in sleep");

   property p_float;
      @(posedge clk) disable iff (rst || !ce)
      (asleep ##1 asleep) |-> !dqOe;
   endproperty
   a_float: assert property (p_float) else $error("outputs driven in sleep");

   property p_recover;
      @(posedge clk) disable iff (rst || !ce)
      ($fell(asleep) && !sleepRequest) ##1 !sleepRequest [*4] |-> recovering;
   endproperty
   a_recover: assert property (p_recover) else $error("recovery ended early");

   property p_no_write;
      @(posedge clk) disable iff (rst)
      recovering |-> !memWrite;
   endproperty
   a_no_write: assert property (p_no_write) else $error("write passed in recovery");

   // First sampled edge only arms the entry phase
   property p_arm;
      @(posedge clk) disable iff (rst || !ce)
      (state == SSMC_RUN && sleepRequest) |=> (state == SSMC_ENTER);
   endproperty
   a_arm: assert property (p_arm) else $error("entry phase not armed");

   // Request dropped during entry falls back to normal operation
   property p_abort;
      @(posedge clk) disable iff (rst || !ce)
      (state == SSMC_ENTER && !sleepRequest) |=> (state == SSMC_RUN);
   endproperty
   a_abort: assert property (p_abort) else $error("entry not abandoned");

   // Data pins released one edge after sleep begins
   property p_release;
      @(posedge clk) disable iff (rst || !ce)
      asleep |=> !dqOe;
   endproperty
   a_release: assert property (p_release) else $error("data pins still driven");

   // Held read data untouched while asleep
   property p_keep;
      @(posedge clk) disable iff (rst || !ce)
      asleep |=> $stable(dqOut);
   endproperty
   a_keep: assert property (p_keep) else $error("held data changed in sleep");

   // Reads still pass during recovery
   property p_read_ok;
      @(posedge clk) disable iff (rst)
      (recovering && cmdSelect && cmdRead) |-> memRead;
   endproperty
   a_read_ok: assert property (p_read_ok) else $error("read blocked in recovery");

   // Recovery start followed by a quiet request line
   sequence s_rec_start;
      $rose(recovering) ##0 !sleepRequest;
   endsequence
   sequence s_rec_quiet;
      !sleepRequest [*4];
   endsequence
   property p_rec_end;
      @(posedge clk) disable iff (rst || !ce)
      s_rec_start ##1 s_rec_quiet |=> !recovering;
   endproperty
   a_rec_end: assert property (p_rec_end) else $error("recovery overran");
endmodule // sram_sleep_mode_control

// ---- hw/ssmc_pkg.sv ----
// Package: constants and types for the SRAM sleep-mode controller
package ssmc_pkg;
   // Clock period in picoseconds (250 MHz)
   localparam int CLK_PERIOD_PS   = 4000;
   // Entry delay in clock cycles, counting the edge that first samples the request high
   localparam int SLEEP_ENTRY_CYC = 2;
   // Least recovery time after the request falls, in ns as printed
   localparam int RECOVERY_NS     = 20;
   // Recovery time in cycles, rounded up, at least one
   localparam int RECOVERY_CYC_RAW = (RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RECOVERY_CYC    = (RECOVERY_CYC_RAW < 1) ? 1 : RECOVERY_CYC_RAW;
   // Width of the phase counter
   localparam int CNT_W           = 4;
   // Counter value after reset
   localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

   // Power phases of the memory
   typedef enum logic [1:0] {
      SSMC_RUN,
      SSMC_ENTER,
      SSMC_SLEEP,
      SSMC_RECOVER
   } ssmc_state_t;

   // Cycle count as counter width
   function automatic logic [CNT_W-1:0] ssmc_cnt(input int n);
      return n[CNT_W-1:0];
   endfunction
endpackage

// ---- hw/ssmc_if.sv ----
// Interface: command gating bundle between controller and gate
`timescale 1ns/100ps
interface ssmc_if #(parameter int DATA_W = 36);
   logic              asleep;
   logic              recovering;
   logic              cmdRead;
   logic              cmdWrite;
   logic              cmdSelect;
   logic [DATA_W-1:0] rdData;
   logic              rdValid;
   logic              memRead;
   logic              memWrite;
   logic              outEn;
   logic [DATA_W-1:0] outData;
   modport ctrl (output asleep, output recovering, input cmdRead, input cmdWrite, input cmdSelect,
                 input rdData, input rdValid);
   modport gate (input asleep, input recovering, input cmdRead, input cmdWrite, input cmdSelect,
                 input rdData, input rdValid, output memRead, output memWrite, output outEn,
                 output outData);
endinterface

// ---- hw/ssmc_gate.sv ----
// Module: command and output gating driven by the power phase
`timescale 1ns/100ps
module ssmc_gate
   import ssmc_pkg::*;
#(
   parameter int DATA_W = 36
) (
   // Clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Bundle
   ssmc_if.gate     bus
);
   logic              outEn;
   logic              next_outEn;
   logic [DATA_W-1:0] outData;
   logic [DATA_W-1:0] next_outData;

   // Commands pass only while awake; writes also blocked in recovery
   assign bus.memRead  = bus.cmdSelect & bus.cmdRead & ~bus.asleep;
   assign bus.memWrite = bus.cmdSelect & bus.cmdWrite & ~bus.asleep & ~bus.recovering;
   assign bus.outEn    = outEn;
   assign bus.outData  = outData;

   // Output driver next state; sleep floats the data pins
   always_comb begin
      next_outEn   = outEn;
      next_outData = outData;
      if (bus.asleep) begin
         next_outEn = 1'b0;
      end else if (bus.rdValid) begin
         next_outEn   = 1'b1;
         next_outData = bus.rdData;
      end else begin
         next_outEn = 1'b0;
      end
   end

   // Output registers
   always_ff @(posedge clk) begin
      if (rst) begin
         outEn   <= 1'b0;
         outData <= '0;
      end else if (ce) begin
         outEn   <= next_outEn;
         outData <= next_outData;
      end
   end
endmodule // ssmc_gate

// ---- sim/ssmc_ctrl_model.sv ----
// Controller model: drives the sleep request and the command levels
`timescale 1ns/100ps
module ssmc_ctrl_model (
   // Clock
   input  wire logic clk,
   // Requests from the bench
   input  wire logic wantSleep,
   input  wire logic wantRead,
   input  wire logic wantWrite,
   input  wire logic badWrite,
   // Device status
   input  wire logic recovering,
   // Commands to the device
   output logic      sleepRequest,
   output logic      cmdSelect,
   output logic      cmdRead,
   output logic      cmdWrite
);
   logic             prevRead;
   logic             turnRead;

   // Quiet lines from time zero
   initial {sleepRequest, cmdSelect, cmdRead, cmdWrite, prevRead} = 5'h00;

   // Read-to-write turnaround gets one dummy read first
   assign turnRead = prevRead & ~wantRead & wantWrite;

   // Sleep raised only with nothing pending; writes held off while recovering unless badWrite
   always @(posedge clk) begin
      sleepRequest <= wantSleep & (sleepRequest | ~(wantRead | wantWrite));
      prevRead     <= wantRead;
      cmdRead      <= wantRead | turnRead;
      cmdWrite     <= wantWrite & ~turnRead & (~recovering | badWrite);
      cmdSelect    <= wantRead | wantWrite;
   end
endmodule // ssmc_ctrl_model

// ---- sim/test_sram_sleep_mode_control.sv ----
// Testbench: sleep-mode sequencer against the controller model
`timescale 1ns/100ps
module test_sram_sleep_mode_control;
   logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, rdValid = 1'b0;
   logic        wantSleep = 1'b0, wantRead = 1'b0, wantWrite = 1'b0, badWrite = 1'b0;
   logic [35:0] rdData = 36'h0;
   logic        sleepRequest, cmdSelect, cmdRead, cmdWrite, memRead, memWrite, dqOe, asleep, recovering;
   logic [35:0] dqOut;
   int          error_cnt = 0;
   int          total_checks = 0;

   // 250 MHz clock
   always #2 clk = ~clk;

   ssmc_ctrl_model i_ssmc_ctrl_model (.clk(clk), .wantSleep(wantSleep), .wantRead(wantRead),
      .wantWrite(wantWrite), .badWrite(badWrite), .recovering(recovering), .sleepRequest(sleepRequest),
      .cmdSelect(cmdSelect), .cmdRead(cmdRead), .cmdWrite(cmdWrite));
   sram_sleep_mode_control #(.DATA_W(36)) i_sram_sleep_mode_control (.clk(clk), .rst(rst), .ce(ce),
      .sleepRequest(sleepRequest), .cmdSelect(cmdSelect), .cmdRead(cmdRead), .cmdWrite(cmdWrite),
      .rdData(rdData), .rdValid(rdValid), .memRead(memRead), .memWrite(memWrite), .dqOut(dqOut),
      .dqOe(dqOe), .asleep(asleep), .recovering(recovering));

   // Flag and data compares
   task automatic chk1(input string n, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic chkd(input string n, input logic [35:0] e, input logic [35:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Bounded wait for the request line level
   task automatic wait_req(input logic lvl);
      int k;
      @(negedge clk);
      for (k = 0; k < 20 && sleepRequest !== lvl; k++) begin
         @(negedge clk);
      end
      chk1("sleepRequest", lvl, sleepRequest);
   endtask

   task automatic t_reset;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
      chk1("asleep", 1'b0, asleep);
      chk1("recovering", 1'b0, recovering);
      chk1("dqOe", 1'b0, dqOe);
      chkd("dqOut", 36'h0, dqOut);
      $display("done reset");
   endtask

   task automatic t_read;
      @(posedge clk);
      rdData <= 36'h9ABCD1234;
      rdValid <= 1'b1;
      wantRead <= 1'b1;
      wantWrite <= 1'b1;
      cyc(2);
      chk1("memRead", 1'b1, memRead);
      chk1("memWrite", 1'b1, memWrite);
      chk1("dqOe", 1'b1, dqOe);
      chkd("dqOut", 36'h9ABCD1234, dqOut);
      @(posedge clk);
      {wantRead, wantWrite, rdValid} <= 3'h0;
      $display("done read");
   endtask

   task automatic t_sleep;
      @(posedge clk);
      wantSleep <= 1'b1;
      wait_req(1'b1);
      cyc(1);
      chk1("asleep", 1'b0, asleep);
      cyc(1);
      chk1("asleep", 1'b1, asleep);
      @(posedge clk);
      {wantRead, wantWrite, rdValid} <= 3'h7;
      rdData <= 36'h0FFFF0000;
      cyc(8);
      chk1("asleep", 1'b1, asleep);
      chk1("memRead", 1'b0, memRead);
      chk1("memWrite", 1'b0, memWrite);
      chk1("dqOe", 1'b0, dqOe);
      chkd("dqOut", 36'h9ABCD1234, dqOut);
      @(posedge clk);
      badWrite <= 1'b1;
      wantSleep <= 1'b0;
      wait_req(1'b0);
      chk1("asleep", 1'b1, asleep);
      cyc(1);
      chk1("asleep", 1'b0, asleep);
      for (int i = 0; i < 5; i++) begin
         chk1("recovering", 1'b1, recovering);
         chk1("memWrite", 1'b0, memWrite);
         chk1("memRead", 1'b1, memRead);
         cyc(1);
      end
      chk1("recovering", 1'b0, recovering);
      chk1("memWrite", 1'b1, memWrite);
      @(posedge clk);
      {wantRead, wantWrite, rdValid, badWrite} <= 4'h0;
      $display("done sleep");
   endtask

   // One-cycle request falls back to normal operation
   task automatic t_abort;
      @(posedge clk);
      wantSleep <= 1'b1;
      @(posedge clk);
      wantSleep <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         cyc(1);
         chk1("asleep", 1'b0, asleep);
         chk1("recovering", 1'b0, recovering);
      end
      $display("done abort");
   endtask

   // Clock enable low holds off entry
   task automatic t_freeze;
      @(posedge clk);
      ce <= 1'b0;
      wantSleep <= 1'b1;
      cyc(6);
      chk1("asleep", 1'b0, asleep);
      @(posedge clk);
      ce <= 1'b1;
      cyc(3);
      chk1("asleep", 1'b1, asleep);
      @(posedge clk);
      wantSleep <= 1'b0;
      cyc(10);
      chk1("recovering", 1'b0, recovering);
      $display("done freeze");
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      t_reset();
      t_read();
      t_sleep();
      t_abort();
      t_freeze();
      final_report();
   end

   // Watchdog at 3000 cycles, far beyond the fewer than one hundred cycles needed
   initial begin
      #(4 * 3000);
      error_cnt++;
      final_report();
   end
endmodule // test_sram_sleep_mode_control
